// ==== src/pcg_gate_cell.sv ====
// Purpose: glitch-free clock gate for one peripheral unit
// Assumes: enable comes from logic on clk_i
// Notes:   latch is transparent while clock is low
`timescale 1ns/100ps
module pcg_gate_cell (
  // clock and enable
  input  wire logic clk_i,
  input  wire logic en_i,
  // gated clock
  output logic      gclk_o
);
  logic en_latched;  // enable held through the high phase

  // latch opens only while the clock is low, so the and gate never chops a pulse
  always_latch begin
    if (!clk_i) begin
      en_latched <= en_i;
    end
  end

  assign gclk_o = clk_i & en_latched;
endmodule

// ==== src/pcg_pkg.sv ====
// Purpose: constants for the peripheral clock gating control block
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes:   one gating register per group and power state
package pcg_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [11:0] PCG_OFF_RUN_CFG = 12'h060;  // run_clock_config
  localparam logic [11:0] PCG_OFF_RUN_G1  = 12'h104;  // run_clock_gate_group1
  localparam logic [11:0] PCG_OFF_RUN_G2  = 12'h108;  // run_clock_gate_group2
  localparam logic [11:0] PCG_OFF_SLP_G1  = 12'h114;  // sleep_clock_gate_group1
  localparam logic [11:0] PCG_OFF_SLP_G2  = 12'h118;  // sleep_clock_gate_group2
  localparam logic [11:0] PCG_OFF_DSL_G1  = 12'h124;  // deep_sleep_clock_gate_group1
  localparam logic [11:0] PCG_OFF_DSL_G2  = 12'h128;  // deep_sleep_clock_gate_group2
  localparam logic [11:0] PCG_OFF_STATUS  = 12'h130;  // fault flag in bit 0, other bits read zero

  // ==========================================================
  // writable bit masks, reserved bits are zero
  localparam logic [31:0] PCG_MASK_G1  = 32'h030F_5037;
  localparam logic [31:0] PCG_MASK_G2  = 32'h5000_00FF;
  localparam logic [31:0] PCG_MASK_CFG = 32'h0800_0000;
  localparam int          PCG_ACG_BIT  = 27;  // auto_sleep_gating_select
  localparam logic [31:0] PCG_RESET    = 32'h0000_0000;

  // group1 field positions
  localparam int PCG_B_TIMER_ZERO_GATE  = 16;
  localparam int PCG_B_COMPARATOR_ZERO_GATE   = 24;
  localparam int PCG_B_TWI1    = 14;
  localparam int PCG_B_TWI0    = 12;
  localparam int PCG_B_SSER1   = 5;
  localparam int PCG_B_SSER0   = 4;
  localparam int PCG_B_ASER0   = 0;
  // group2 field positions
  localparam int PCG_B_EPHY    = 30;
  localparam int PCG_B_EMAC    = 28;
  localparam int PCG_B_PORTA   = 0;

  // power states
  typedef enum logic [1:0] {
    PCG_PWR_RUN,
    PCG_PWR_SLEEP,
    PCG_PWR_DEEP
  } pcg_pwr_e;

  // one group select per unit access: 0 = group1, 1 = group2
  localparam int PCG_UNIT_W = 5;  // unit index width

endpackage

// ==== src/pcg_top.sv ====
// Purpose: peripheral clock gating registers with bus fault on gated units
// Assumes: classic wishbone, one wait-free answer cycle after request
// Notes:   gated clocks are combinational outputs of gating cells
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/100ps
module pcg_top
  import pcg_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // register bus
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [11:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  output logic             err_o,
  // power state from the core
  input  wire logic        sleep_i,
  input  wire logic        deep_sleep_i,
  // peripheral access check
  input  wire logic        unit_req_i,
  input  wire logic        unit_grp_i,
  input  wire logic [4:0]  unit_idx_i,
  output logic             unit_fault_o,
  // clock enables and gated clocks
  output logic [31:0]      en_g1_o,
  output logic [31:0]      en_g2_o,
  output logic [31:0]      gclk_g1_o,
  output logic [31:0]      gclk_g2_o
);

  // ==========================================================
  // registers
  logic [31:0] run_clock_config;
  logic [31:0] run_g1, run_g2, slp_g1, slp_g2, dsl_g1, dsl_g2;
  logic        fault_seen;  // sticky record of a faulted access

  // ==========================================================
  // byte-lane merge used by every config and gating register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel, input logic [31:0] mask);
    logic [31:0] lanes;
    lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    merge = ((old & ~lanes) | (nw & lanes)) & mask;
  endfunction

  // ==========================================================
  // bus decode
  wire req     = cyc_i & stb_i & ~ack_o & ~err_o;
  wire wr      = req & we_i;
  wire hit_cfg = adr_i == PCG_OFF_RUN_CFG;
  wire hit_rg1 = adr_i == PCG_OFF_RUN_G1;
  wire hit_rg2 = adr_i == PCG_OFF_RUN_G2;
  wire hit_sg1 = adr_i == PCG_OFF_SLP_G1;
  wire hit_sg2 = adr_i == PCG_OFF_SLP_G2;
  wire hit_dg1 = adr_i == PCG_OFF_DSL_G1;
  wire hit_dg2 = adr_i == PCG_OFF_DSL_G2;
  wire hit_sts = adr_i == PCG_OFF_STATUS;
  wire hit_any = hit_cfg | hit_rg1 | hit_rg2 | hit_sg1 | hit_sg2 | hit_dg1 | hit_dg2 | hit_sts;

  // ==========================================================
  // power state and active register selection
  wire      auto_sleep_gating_select = run_clock_config[PCG_ACG_BIT];
  pcg_pwr_e pwr;
  assign pwr = deep_sleep_i ? PCG_PWR_DEEP : (sleep_i ? PCG_PWR_SLEEP : PCG_PWR_RUN);

  logic [31:0] next_en_g1, next_en_g2;
  // sleep copies count only with auto gating set, else run copies stay
  always_comb begin
    case (auto_sleep_gating_select ? pwr : PCG_PWR_RUN)
      PCG_PWR_SLEEP: begin
        next_en_g1 = slp_g1;
        next_en_g2 = slp_g2;
      end
      PCG_PWR_DEEP: begin
        next_en_g1 = dsl_g1;
        next_en_g2 = dsl_g2;
      end
      default: begin
        next_en_g1 = run_g1;
        next_en_g2 = run_g2;
      end
    endcase
  end

  // read mux
  wire [31:0] rd_data =
    hit_cfg ? run_clock_config :
    hit_rg1 ? run_g1 : hit_rg2 ? run_g2 :
    hit_sg1 ? slp_g1 : hit_sg2 ? slp_g2 :
    hit_dg1 ? dsl_g1 : hit_dg2 ? dsl_g2 :
    hit_sts ? {31'h0000_0000, fault_seen} : 32'h0000_0000;

  // unit access check: enable bit selected from the live enables
  wire unit_on = unit_grp_i ? en_g2_o[unit_idx_i] : en_g1_o[unit_idx_i];

  // ==========================================================
  // register writes; fault flag set wins over its clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_clock_config <= PCG_RESET;
      run_g1           <= PCG_RESET;
      run_g2           <= PCG_RESET;
      slp_g1           <= PCG_RESET;
      slp_g2           <= PCG_RESET;
      dsl_g1           <= PCG_RESET;
      dsl_g2           <= PCG_RESET;
      fault_seen       <= 1'b0;
    end else begin
      if (wr & hit_cfg) run_clock_config <= merge(run_clock_config, dat_i, sel_i, PCG_MASK_CFG);
      if (wr & hit_rg1) run_g1 <= merge(run_g1, dat_i, sel_i, PCG_MASK_G1);
      if (wr & hit_rg2) run_g2 <= merge(run_g2, dat_i, sel_i, PCG_MASK_G2);
      if (wr & hit_sg1) slp_g1 <= merge(slp_g1, dat_i, sel_i, PCG_MASK_G1);
      if (wr & hit_sg2) slp_g2 <= merge(slp_g2, dat_i, sel_i, PCG_MASK_G2);
      if (wr & hit_dg1) dsl_g1 <= merge(dsl_g1, dat_i, sel_i, PCG_MASK_G1);
      if (wr & hit_dg2) dsl_g2 <= merge(dsl_g2, dat_i, sel_i, PCG_MASK_G2);
      // write one to bit 0 clears, a fault in the same cycle keeps it set
      if (unit_req_i & ~unit_on) begin
        fault_seen <= 1'b1;
      end else if (wr & hit_sts & sel_i[0] & dat_i[0]) begin
        fault_seen <= 1'b0;
      end
    end
  end

  // ==========================================================
  // bus answer: one cycle after request, err for unmapped address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req & hit_any;
      err_o <= req & ~hit_any;
      dat_o <= (req & ~we_i) ? rd_data : 32'h0000_0000;
    end
  end

  // ==========================================================
  // live enables and fault answer, registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_g1_o      <= PCG_RESET;
      en_g2_o      <= PCG_RESET;
      unit_fault_o <= 1'b0;
    end else begin
      en_g1_o      <= next_en_g1;
      en_g2_o      <= next_en_g2;
      unit_fault_o <= unit_req_i & ~unit_on;
    end
  end

  // ==========================================================
  // gating cells, one per bit; reserved bits stay dark
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_cell
      pcg_gate_cell u_g1 (
        .clk_i  (clk_i),
        .en_i   (en_g1_o[gi]),
        .gclk_o (gclk_g1_o[gi])
      );
      pcg_gate_cell u_g2 (
        .clk_i  (clk_i),
        .en_i   (en_g2_o[gi]),
        .gclk_o (gclk_g2_o[gi])
      );
    end
  endgenerate

endmodule

// ==== tb/pcg_assertions.sv ====
// Purpose: port checks for the clock gating block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to pcg_top after the module
`timescale 1ns/100ps
module pcg_checker
  import pcg_pkg::*;
(
  // clock, reset, bus and power state
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic        err_o,
  input wire logic        sleep_i,
  input wire logic        deep_sleep_i,
  // unit access check
  input wire logic        unit_req_i,
  input wire logic        unit_grp_i,
  input wire logic [4:0]  unit_idx_i,
  input wire logic        unit_fault_o,
  // enables and gated clocks
  input wire logic [31:0] en_g1_o,
  input wire logic [31:0] en_g2_o,
  input wire logic [31:0] gclk_g1_o,
  input wire logic [31:0] gclk_g2_o
);
  // ========================================
  // properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a request the slave must take now
  sequence s_take; cyc_i && stb_i && !ack_o && !err_o; endsequence
  // an access aimed at a unit whose clock is off
  sequence s_g1_off; unit_req_i && !unit_grp_i && !en_g1_o[unit_idx_i]; endsequence
  sequence s_g2_off; unit_req_i && unit_grp_i && !en_g2_o[unit_idx_i]; endsequence
  a_ack_timely: assert property (s_take |=> ack_o || err_o) else $error("no bus answer");
  a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  a_fault_g1: assert property (s_g1_off |=> unit_fault_o) else $error("no fault, group1");
  a_fault_g2: assert property (s_g2_off |=> unit_fault_o) else $error("no fault, group2");
  a_fault_cause: assert property (!unit_req_i |=> !unit_fault_o) else $error("fault without access");
  a_rsv_quiet: assert property (((en_g1_o & ~PCG_MASK_G1) | (en_g2_o & ~PCG_MASK_G2)) == 0)
    else $error("reserved enable set");
  a_reset_zero: assert property ($fell(rst_i) |-> (en_g1_o | en_g2_o) == 0) else $error("enable after reset");
  a_gclk_low: assert property ((gclk_g1_o | gclk_g2_o) == 0) else $error("gated clock high while clock low");
  // in the high phase each gated clock carries the enable held before the rising edge
  a_gclk_follow: assert property (@(negedge clk_i) (gclk_g1_o == $past(en_g1_o)) && (gclk_g2_o == $past(en_g2_o)))
    else $error("gated clock does not follow its enable");
  // group1 enables move only after a bus answer or a power state change
  a_en_cause: assert property ($changed(en_g1_o) |-> $past(ack_o) || $past(sleep_i) != $past(sleep_i, 2) ||
    $past(deep_sleep_i) != $past(deep_sleep_i, 2))
    else $error("enable changed without cause");
endmodule
bind pcg_top pcg_checker u_pcg_checker (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .err_o, .sleep_i, .deep_sleep_i,
  .unit_req_i,
  .unit_grp_i, .unit_idx_i, .unit_fault_o, .en_g1_o, .en_g2_o, .gclk_g1_o, .gclk_g2_o);

// ==== tb/pcg_top_tb.sv ====
// Purpose: self-checking bench for the clock gating block
// Assumes: wishbone answer one cycle after the request is taken
// Notes:   expectations come from the package masks and offsets
`timescale 1ns/100ps
module pcg_top_tb;
  import pcg_pkg::*;
  // ========================================
  // signals
  logic clk_i, rst_i, cyc_i, stb_i, we_i, sleep_i, deep_sleep_i, unit_req_i, unit_grp_i;
  logic [11:0] adr_i;
  logic [3:0]  sel_i;
  logic [4:0]  unit_idx_i;
  logic [31:0] dat_i, dat_o, en_g1_o, en_g2_o, gclk_g1_o, gclk_g2_o, rd;
  logic        ack_o, err_o, unit_fault_o, er;
  int          n_errors, total_checks;
  localparam logic [11:0] OFFS [7] = '{PCG_OFF_RUN_CFG, PCG_OFF_RUN_G1, PCG_OFF_RUN_G2, PCG_OFF_SLP_G1,
    PCG_OFF_SLP_G2, PCG_OFF_DSL_G1, PCG_OFF_DSL_G2};
  localparam logic [31:0] MSKS [7] = '{PCG_MASK_CFG, PCG_MASK_G1, PCG_MASK_G2, PCG_MASK_G1, PCG_MASK_G2,
    PCG_MASK_G1, PCG_MASK_G2};
  pcg_top u_pcg_top (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .err_o,
    .sleep_i, .deep_sleep_i, .unit_req_i, .unit_grp_i, .unit_idx_i, .unit_fault_o, .en_g1_o, .en_g2_o,
    .gclk_g1_o, .gclk_g2_o);
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ========================================
  // tasks
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // one classic cycle; waits for ack or err, only the watchdog ends a hang
  task wb(input logic w, input logic [11:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, s, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (!(ack_o || err_o));
    rd = dat_o;
    er = err_o;
    chk("bus_latency", 32'h0000_0002, n);
    {cyc_i, stb_i} <= 2'b00;
  endtask
  // one access attempt to a unit, fault sampled a cycle later
  task unit(input logic g, input logic [4:0] i, input logic exp);
    @(posedge clk_i);
    {unit_req_i, unit_grp_i, unit_idx_i} <= {1'b1, g, i};
    @(posedge clk_i);
    unit_req_i <= 1'b0;
    @(posedge clk_i);
    chk("unit_fault", {31'h0, exp}, {31'h0, unit_fault_o});
  endtask
  task settle;
    repeat (2) @(posedge clk_i);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ========================================
  // tests
  initial begin
    {rst_i, cyc_i, stb_i, we_i, sleep_i, deep_sleep_i, unit_req_i, unit_grp_i} = 8'h80;
    {adr_i, sel_i, unit_idx_i, dat_i} = '0;
    n_errors = 0;
    total_checks = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int k = 0; k < 7; k++) begin
      wb(1'b0, OFFS[k], 4'hF, 32'h0);
      chk("reset_reg", 32'h0, rd);
      wb(1'b1, OFFS[k], 4'hF, 32'hFFFF_FFFF);
      wb(1'b0, OFFS[k], 4'hF, 32'h0);
      chk("reg_mask", MSKS[k], rd);
    end
    settle();
    chk("en_g1", PCG_MASK_G1, en_g1_o);
    chk("en_g2", PCG_MASK_G2, en_g2_o);
    $display("test registers done");
    // gated units fault, clocked ones do not
    for (int i = 0; i < 32; i++) begin
      unit(1'b0, i[4:0], !PCG_MASK_G1[i]);
      unit(1'b1, i[4:0], !PCG_MASK_G2[i]);
    end
    wb(1'b1, 12'h200, 4'hF, 32'h1);
    chk("err_unmapped", 32'h1, {31'h0, er});
    // sticky fault flag seen, then cleared by writing one
    wb(1'b0, PCG_OFF_STATUS, 4'hF, 32'h0);
    chk("fault_flag", 32'h1, rd);
    wb(1'b1, PCG_OFF_STATUS, 4'h1, 32'h1);
    wb(1'b0, PCG_OFF_STATUS, 4'hF, 32'h0);
    chk("fault_clear", 32'h0, rd);
    // lane 0 only: serial gates off, timers stay on
    wb(1'b1, PCG_OFF_RUN_G1, 4'h1, 32'h0);
    settle();
    chk("en_lane", 32'h030F_5000, en_g1_o);
    unit(1'b0, 5'd0, 1'b1);
    $display("test faults done");
    // sleep copies need auto gating, deep wins
    wb(1'b1, PCG_OFF_SLP_G1, 4'hF, 32'h0000_0010);
    wb(1'b1, PCG_OFF_DSL_G1, 4'hF, 32'h0001_0000);
    wb(1'b1, PCG_OFF_DSL_G2, 4'hF, 32'h1000_0080);
    sleep_i <= 1'b1;
    settle();
    chk("en_sleep", 32'h0000_0010, en_g1_o);
    deep_sleep_i <= 1'b1;
    settle();
    chk("en_deep", 32'h0001_0000, en_g1_o);
    chk("en_deep2", 32'h1000_0080, en_g2_o);
    wb(1'b1, PCG_OFF_RUN_CFG, 4'hF, 32'h0);
    settle();
    chk("en_no_auto", 32'h030F_5000, en_g1_o);
    $display("test power done");
    rst_i <= 1'b1;
    settle();
    rst_i <= 1'b0;
    wb(1'b0, PCG_OFF_RUN_G1, 4'hF, 32'h0);
    chk("rerst_reg", 32'h0, rd);
    chk("rerst_en", 32'h0, en_g1_o | en_g2_o);
    $display("test reset done");
    end_sim();
  end
  initial begin
    #100us;
    n_errors++;
    end_sim();
  end
endmodule
